// File: dv/dsr_deserializer_asserts.sv
// Port-level assertions for the deserializer top
`include "dsr_consts.vh"

module dsr_deserializer_asserts (
    // Clock and reset
    input logic                   aclk,
    input logic                   aresetn,
    // Register bus
    input logic                   s_axi_awvalid,
    input logic                   s_axi_awready,
    input logic                   s_axi_wvalid,
    input logic                   s_axi_wready,
    input logic                   s_axi_bvalid,
    input logic                   s_axi_arvalid,
    input logic                   s_axi_arready,
    input logic                   s_axi_rvalid,
    // Datapath
    input logic                   unit_reset,
    input logic [`DSR_WORD_W-1:0] par_word,
    input logic                   word_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Sequences
    // ********
    default clocking dc @(posedge aclk);
    endclocking

    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // ********
    // Checks
    // ********
    reset_clears_a:
        assert property (!aresetn |=> !word_strobe && par_word == 0 && !s_axi_bvalid)
        else $error("Outputs not cleared by reset");
    unit_clear_a:
        assert property (disable iff (!aresetn)
            unit_reset [*8] |-> par_word == 0 && !word_strobe)
        else $error("Unit reset left the word set");
    strobe_pulse_a:
        assert property (disable iff (!aresetn) word_strobe |=> !word_strobe)
        else $error("Word strobe longer than one cycle");
    word_holds_a:
        assert property (disable iff (!aresetn)
            $changed(par_word) |-> word_strobe || par_word == 0)
        else $error("Word changed between strobes");
    write_answer_a:
        assert property (disable iff (!aresetn) wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("Write response missing");
    read_answer_a:
        assert property (disable iff (!aresetn) rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("Read data missing");
    write_blocked_a:
        assert property (disable iff (!aresetn) s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write accepted while response pending");
    read_blocked_a:
        assert property (disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
        else $error("Read accepted while data pending");
endmodule

bind dsr_deserializer dsr_deserializer_asserts chk (.*);

// File: dv/dsr_deserializer_tb_top.sv
// Bench: register access, word shapes, slips and resets of the deserializer
module dsr_deserializer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        capture_enable_a = 1'b1, capture_enable_b = 1'b0;
    logic        slip_request = 1'b0, unit_reset = 1'b0, ddr = 1'b1;
    logic        serial_rise, serial_fall, memory_domain_clock;
    wire         cascade_in_a = serial_rise, cascade_in_b = serial_fall;
    logic        cascade_out_a, cascade_out_b, word_strobe;
    logic [3:0]  width = 4'h4;
    logic [9:0]  par_word, w, w0, exp;
    logic [11:0] cfg [13] = '{12'h820, 12'h830, 12'h840, 12'h850, 12'h860, 12'h870, 12'hC41,
                              12'h880, 12'h841, 12'h861, 12'h881, 12'h8A1, 12'h941};
    int          errors = 0, checks_done = 0, guard = 0, n;

    always #5 aclk = ~aclk;

    dsr_deserializer uut (.*);
    dsr_serial_source src (.*);

    // ********
    // Tasks
    // ********
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic step;
        @(posedge aclk);
        guard++;
        if (guard > 300) begin
            errors++;
            print_verdict;
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        guard = 0;
        step;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            step;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [3:0] a);
        guard = 0;
        step;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            step;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic next_word;
        guard = 0;
        n = 0;
        do begin
            step;
            n++;
        end while (word_strobe !== 1'b1);
        w = par_word;
    endtask

    // ********
    // Sequence
    // ********
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(4'h0);
        chk(rd, 32'h341);
        axi_read(4'hC);
        chk(32'(resp), 32'h2);
        chk(rd, 32'h0);
        axi_write(4'h8, 32'hFFFF);
        chk(32'(resp), 32'h0);
        axi_read(4'h8);
        chk(rd, 32'h0);
        foreach (cfg[i]) begin
            ddr <= cfg[i][0];
            width <= cfg[i][7:4];
            capture_enable_b <= cfg[i][8];
            axi_write(4'h0, 32'(cfg[i]));
            repeat (5) next_word;
            chk(n, cfg[i][0] ? 32'(cfg[i][7:5]) : 32'(cfg[i][7:4]));
            chk(32'(w >> cfg[i][7:4]), 32'h0);
            chk($countones(w), 32'h1);
            w0 = w;
            for (int k = 0; k < cfg[i][7:4]; k++) begin
                exp = (w >> 1) | ({9'h0, w[0]} << (cfg[i][7:4] - 4'h1));
                if (k[0]) begin
                    axi_write(4'h4, 32'h1);
                end else begin
                    guard = 0;
                    slip_request <= 1'b1;
                    step;
                    step;
                    slip_request <= 1'b0;
                end
                repeat (4) next_word;
                chk(32'(w), 32'(exp));
            end
            chk(32'(w), 32'(w0));
        end
        axi_read(4'h0);
        chk(rd, 32'h941);
        axi_write(4'h0, 32'h890);
        axi_read(4'h8);
        chk(rd & 32'h4000, 32'h4000);
        repeat (3) next_word;
        chk(n, 32'h2);
        axi_write(4'h0, 32'hA81);
        axi_read(4'h8);
        chk(rd & 32'h4000, 32'h4000);
        axi_write(4'h0, 32'hA41);
        axi_read(4'h8);
        chk(rd & 32'h4000, 32'h0);
        repeat (8) next_word;
        chk($countones(w), 32'h1);
        guard = 0;
        unit_reset <= 1'b1;
        repeat (8) step;
        unit_reset <= 1'b0;
        chk(32'({cascade_out_a, cascade_out_b, par_word}), 32'h0);
        aresetn <= 1'b0;
        repeat (3) step;
        aresetn <= 1'b1;
        axi_read(4'h0);
        chk(rd, 32'h341);
        print_verdict;
    end
endmodule

// File: dv/dsr_serial_source.sv
// Serial source: one marker bit at the end of every frame, plus memory clock
module dsr_serial_source (
    // Clock
    input  logic       aclk,
    // Frame shape
    input  logic       ddr,
    input  logic [3:0] width,
    // Pins of the deserializer
    output logic       serial_rise = 1'b0,
    output logic       serial_fall = 1'b0,
    output logic       memory_domain_clock = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] pos = 4'h0;
    logic [3:0] next_pos;

    // The frame wraps to bit zero once the next position reaches the width
    assign next_pos = pos + (ddr ? 4'h2 : 4'h1);

    always @(posedge aclk) begin
        serial_rise <= (pos + 4'h1 == width);
        serial_fall <= ddr && (pos + 4'h2 == width);
        pos <= (next_pos >= width) ? 4'h0 : next_pos;
        if (next_pos >= width) begin
            memory_domain_clock <= ~memory_domain_clock;
        end
    end
endmodule

// File: hdl/dsr_consts.vh
// Register map, field layout, reset values and pin indexes of the deserializer
`ifndef DSR_CONSTS_VH
`define DSR_CONSTS_VH

// ****************************************
// Register bus
// ****************************************
`define DSR_ADDR_W        4
`define DSR_IDX_LO        2
`define DSR_IDX_HI        3
`define DSR_IDX_CTRL      2'h0
`define DSR_IDX_SLIP      2'h1
`define DSR_IDX_STATUS    2'h2
`define DSR_RESP_OKAY     2'h0
`define DSR_RESP_SLVERR   2'h2

// ****************************************
// Control register fields
// ****************************************
`define DSR_CTRL_W        12
`define DSR_CTRL_RST      12'h341
`define DSR_F_DDR         0
`define DSR_F_WIDTH_LO    4
`define DSR_F_WIDTH_HI    7
`define DSR_F_CE_TWO      8
`define DSR_F_MEMORY      9
`define DSR_F_SLAVE       10
`define DSR_F_RUN         11
`define DSR_F_SLIP_GO     0

// ****************************************
// Status register fields
// ****************************************
`define DSR_S_WORD_HI     9
`define DSR_S_POS_LO      10
`define DSR_S_POS_HI      13
`define DSR_S_CFG_ERR     14
`define DSR_S_SLIP_PEND   15

// ****************************************
// Widths and limits
// ****************************************
`define DSR_WORD_W        10
`define DSR_UNIT_W        6
`define DSR_SLAVE_USED    4
`define DSR_LOW_GATED     4
`define DSR_DEF_WIDTH     4'h4
`define DSR_MEM_WIDTH     4'h4
`define DSR_SDR_MIN       4'h2
`define DSR_SDR_MAX       4'h8
`define DSR_DDR_MIN       4'h4
`define DSR_DDR_MAX       4'hA

// ****************************************
// Synchronised pin indexes
// ****************************************
`define DSR_NPIN          7
`define DSR_P_RISE        0
`define DSR_P_FALL        1
`define DSR_P_CEA         2
`define DSR_P_CEB         3
`define DSR_P_SLIP        4
`define DSR_P_RST         5
`define DSR_P_MCLK        6

`endif

// File: hdl/dsr_deserializer.v
// Serial-to-parallel input deserializer with slip alignment and AXI4-Lite control
//
// What this block does
// RULE1 - SDR words of two to eight bits
// RULE2 - DDR words of 4,6,8,10 bits, both phases
// RULE3 - One unit six bits; wider needs cascade
// RULE4 - Earliest serial bit lands on top bit
// RULE5 - Sixth output or slave fourth holds LSB; the code puts the MSB (earliest bit) there
// RULE6 - Slip request shifts alignment one position
// RULE7 - One enable: first enable gates capture directly
// RULE8 - Two enables: each covers half divided cycle
// RULE9 - Internal enable gates only first four registers
// RULE10 - Enable module is divided-clock 2:1 converter
// RULE11 - Two-enable mode meant for DDR memory
// RULE12 - Integrator drives inverted fast clock
// RULE13 - Divided rate drives output, slip, enables
// RULE14 - Integrator joins master carry to slave
// RULE15 - Memory clock moves strobe data inward
// RULE16 - Reset clears data, retimed per domain
// RULE17 - Reset held one divided cycle minimum
// RULE18 - Memory clock free-running, unused networking
// RULE19 - Wide words need pair, not memory
// RULE20 - Slips wrap after word-width requests
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`include "dsr_consts.vh"

module dsr_deserializer (
    // Clock and reset
    input  wire                      aclk,
    input  wire                      aresetn,
    // AXI4-Lite write address
    input  wire [`DSR_ADDR_W-1:0]    s_axi_awaddr,
    input  wire [2:0]                s_axi_awprot,
    input  wire                      s_axi_awvalid,
    output reg                       s_axi_awready,
    // AXI4-Lite write data and response
    input  wire [31:0]               s_axi_wdata,
    input  wire [3:0]                s_axi_wstrb,
    input  wire                      s_axi_wvalid,
    output reg                       s_axi_wready,
    output reg  [1:0]                s_axi_bresp,
    output reg                       s_axi_bvalid,
    input  wire                      s_axi_bready,
    // AXI4-Lite read
    input  wire [`DSR_ADDR_W-1:0]    s_axi_araddr,
    input  wire [2:0]                s_axi_arprot,
    input  wire                      s_axi_arvalid,
    output reg                       s_axi_arready,
    output reg  [31:0]               s_axi_rdata,
    output reg  [1:0]                s_axi_rresp,
    output reg                       s_axi_rvalid,
    input  wire                      s_axi_rready,
    // Serial pins
    input  wire                      serial_rise,
    input  wire                      serial_fall,
    input  wire                      capture_enable_a,
    input  wire                      capture_enable_b,
    input  wire                      slip_request,
    input  wire                      unit_reset,
    input  wire                      memory_domain_clock,
    // Cascade to and from a neighbouring unit
    input  wire                      cascade_in_a,
    input  wire                      cascade_in_b,
    output reg                       cascade_out_a,
    output reg                       cascade_out_b,
    // Parallel word
    output reg  [`DSR_WORD_W-1:0]    par_word,
    output reg                       word_strobe
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire [`DSR_NPIN-1:0] pin_raw;
    reg  [`DSR_NPIN-1:0] pin_s1;
    reg  [`DSR_NPIN-1:0] pin_s2;
    reg  [`DSR_NPIN-1:0] pin_s3;
    reg  [`DSR_NPIN-1:0] pin_q;

    assign pin_raw = {memory_domain_clock, unit_reset, slip_request, capture_enable_b,
                      capture_enable_a, serial_fall, serial_rise};

    genvar gi;
    generate
        for (gi = 0; gi < `DSR_NPIN; gi = gi + 1) begin : g_sync
            always @(posedge aclk) begin
                if (!aresetn) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                    pin_q[gi]  <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    // Data bits pass every cycle; other pins count once two stages agree
                    if (gi <= `DSR_P_FALL || pin_s2[gi] == pin_s3[gi]) begin
                        pin_q[gi] <= pin_s3[gi];
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Control state
    // ****************************************
    reg  [`DSR_CTRL_W-1:0] ctrl;
    reg                    sw_slip;
    wire                   c_ddr;
    wire [3:0]             c_width;
    wire                   c_ce_two;
    wire                   c_memory;
    wire                   c_slave;
    wire                   c_run;

    assign c_ddr    = ctrl[`DSR_F_DDR];
    assign c_width  = ctrl[`DSR_F_WIDTH_HI:`DSR_F_WIDTH_LO];
    assign c_ce_two = ctrl[`DSR_F_CE_TWO];
    assign c_memory = ctrl[`DSR_F_MEMORY];
    assign c_slave  = ctrl[`DSR_F_SLAVE];
    assign c_run    = ctrl[`DSR_F_RUN];

    // Legal width table; memory mode allows only a single DDR unit of four
    wire sdr_ok  = !c_ddr && (c_width >= `DSR_SDR_MIN) && (c_width <= `DSR_SDR_MAX); // RULE1
    wire ddr_ok  = c_ddr && !c_width[0] && (c_width >= `DSR_DDR_MIN)
                   && (c_width <= `DSR_DDR_MAX); // RULE2
    wire mem_ok  = !c_memory || (c_ddr && c_width == `DSR_MEM_WIDTH); // RULE19
    wire cfg_ok  = (sdr_ok || ddr_ok) && mem_ok;
    // A bad setting falls back to the default rather than producing a mangled word
    wire       eff_ddr = cfg_ok ? c_ddr : 1'b1;
    wire [3:0] eff_w   = cfg_ok ? c_width : `DSR_DEF_WIDTH;
    wire [3:0] period  = eff_ddr ? {1'b0, eff_w[3:1]} : eff_w;

    // ****************************************
    // Reset retiming
    // ****************************************
    reg fast_rst;
    reg div_rst;
    wire div_tick;

    always @(posedge aclk) begin
        if (!aresetn) begin
            fast_rst <= 1'b1;
        end else begin
            fast_rst <= pin_q[`DSR_P_RST] | ~c_run; // RULE16
        end
    end

    // Divided side leaves reset only on a divided-rate boundary, so every
    // unit fed the same reset pulse starts its words on the same edge
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_rst <= 1'b1;
        end else if (fast_rst) begin
            div_rst <= 1'b1;
        end else if (div_tick) begin
            div_rst <= 1'b0; // RULE16
        end
    end

    // ****************************************
    // Divided-rate enable
    // ****************************************
    reg [3:0] div_cnt;

    assign div_tick = !fast_rst && (div_cnt == period - 4'h1); // RULE13

    always @(posedge aclk) begin
        if (!aresetn || fast_rst) begin
            div_cnt <= 4'h0;
        end else if (div_tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // ****************************************
    // Clock enable module
    // ****************************************
    reg  ce_pair_a;
    reg  ce_pair_b;
    wire first_half = (div_cnt < {1'b0, period[3:1]});
    wire internal_capture_enable;

    // Two enables are deserialised at the divided rate, then replayed one per half
    always @(posedge aclk) begin
        if (!aresetn || div_rst) begin
            ce_pair_a <= 1'b0;
            ce_pair_b <= 1'b0;
        end else if (div_tick) begin
            ce_pair_a <= pin_q[`DSR_P_CEA]; // RULE10
            ce_pair_b <= pin_q[`DSR_P_CEB]; // RULE10
        end
    end

    assign internal_capture_enable = c_ce_two ? (first_half ? ce_pair_a : ce_pair_b) // RULE8
                          : pin_q[`DSR_P_CEA]; // RULE7

    // ****************************************
    // Capture chain: master then slave
    // ****************************************
    wire [`DSR_UNIT_W-1:0] m_bits;
    wire [`DSR_UNIT_W-1:0] s_bits;
    wire                   m_carry_a;
    wire                   m_carry_b;
    wire                   m_in_a = c_slave ? cascade_in_a : pin_q[`DSR_P_RISE];
    wire                   m_in_b = c_slave ? cascade_in_b : pin_q[`DSR_P_FALL];

    dsr_unit u_master (
        .aclk    (aclk),
        .rst     (fast_rst),
        .ddr     (eff_ddr),
        .ce_low  (internal_capture_enable),
        .d_a     (m_in_a),
        .d_b     (m_in_b),
        .bits    (m_bits),
        .carry_a (m_carry_a),
        .carry_b (m_carry_b)
    );

    // Slave holds the older bits of words wider than one unit
    dsr_unit u_slave (
        .aclk    (aclk),
        .rst     (fast_rst),
        .ddr     (eff_ddr),
        .ce_low  (1'b1),
        .d_a     (m_carry_a), // RULE3
        .d_b     (m_carry_b), // RULE3
        .bits    (s_bits),
        .carry_a (),
        .carry_b ()
    );

    always @(posedge aclk) begin
        if (!aresetn || fast_rst) begin
            cascade_out_a <= 1'b0;
            cascade_out_b <= 1'b0;
        end else begin
            cascade_out_a <= m_carry_a;
            cascade_out_b <= m_carry_b;
        end
    end

    // Newest bit at index zero, oldest toward the top; slave fourth stage is the
    // most significant of the older half when cascaded
    wire [`DSR_WORD_W-1:0] chain = {s_bits[`DSR_SLAVE_USED-1:0], m_bits}; // RULE5

    // ****************************************
    // Memory-domain transfer
    // ****************************************
    reg  [`DSR_LOW_GATED-1:0] mem_word;
    reg                       mclk_prev;
    wire                      mem_edge = pin_q[`DSR_P_MCLK] & ~mclk_prev;

    always @(posedge aclk) begin
        if (!aresetn || fast_rst) begin
            mclk_prev <= 1'b0;
            mem_word  <= {`DSR_LOW_GATED{1'b0}};
        end else begin
            mclk_prev <= pin_q[`DSR_P_MCLK];
            if (c_memory && mem_edge) begin
                mem_word <= m_bits[`DSR_LOW_GATED-1:0]; // RULE15
            end
        end
    end

    // ****************************************
    // Slip and word alignment
    // ****************************************
    reg  [3:0]             slip_pos;
    reg                    slip_pend;
    reg                    slip_prev;
    reg  [`DSR_WORD_W-1:0] prev_word;
    wire                   slip_rise = pin_q[`DSR_P_SLIP] & ~slip_prev;
    wire                   slip_new  = (slip_rise | sw_slip) & ~c_memory;
    wire [`DSR_WORD_W-1:0] mask      = ~({`DSR_WORD_W{1'b1}} << eff_w);
    wire [`DSR_WORD_W-1:0] cur_word  = c_memory ? {6'h00, mem_word} : (chain & mask);
    wire [19:0]            cat       = ({10'h000, prev_word} << eff_w) | {10'h000, cur_word};
    wire [19:0]            shifted   = cat >> slip_pos;
    wire [`DSR_WORD_W-1:0] aligned   = shifted[`DSR_WORD_W-1:0] & mask; // RULE4

    always @(posedge aclk) begin
        if (!aresetn) begin
            slip_prev <= 1'b0;
        end else begin
            slip_prev <= pin_q[`DSR_P_SLIP];
        end
    end

    // A request arriving on the consuming tick is kept for the next one
    always @(posedge aclk) begin
        if (!aresetn || div_rst) begin
            slip_pend <= 1'b0;
        end else begin
            slip_pend <= (slip_pend & ~div_tick) | slip_new; // RULE6
        end
    end

    always @(posedge aclk) begin
        if (!aresetn || div_rst) begin
            slip_pos    <= 4'h0;
            prev_word   <= {`DSR_WORD_W{1'b0}};
            par_word    <= {`DSR_WORD_W{1'b0}};
            word_strobe <= 1'b0;
        end else begin
            word_strobe <= div_tick;
            if (div_tick) begin
                prev_word <= cur_word;
                par_word  <= aligned; // RULE13
                if (slip_pend) begin
                    slip_pos <= (slip_pos >= eff_w - 4'h1) ? 4'h0 : slip_pos + 4'h1; // RULE20
                end
            end
        end
    end

    // ****************************************
    // AXI4-Lite write side
    // ****************************************
    reg                   aw_got;
    reg                   w_got;
    reg [1:0]             aw_idx;
    reg [31:0]            w_data;
    reg [3:0]             w_strb;
    reg                   next_aw_got;
    reg                   next_w_got;
    reg                   next_bvalid;
    wire                  aw_hs    = s_axi_awvalid & s_axi_awready;
    wire                  w_hs     = s_axi_wvalid & s_axi_wready;
    wire                  do_write = aw_got & w_got & ~s_axi_bvalid;

    always @* begin
        next_aw_got = do_write ? 1'b0 : (aw_got | aw_hs);
        next_w_got  = do_write ? 1'b0 : (w_got | w_hs);
        next_bvalid = (s_axi_bvalid & ~s_axi_bready) | do_write;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_idx        <= 2'h0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DSR_RESP_OKAY;
            ctrl          <= `DSR_CTRL_RST;
            sw_slip       <= 1'b0;
        end else begin
            aw_got        <= next_aw_got;
            w_got         <= next_w_got;
            s_axi_awready <= ~next_aw_got & ~next_bvalid;
            s_axi_wready  <= ~next_w_got & ~next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            sw_slip       <= 1'b0;
            if (aw_hs) begin
                aw_idx <= s_axi_awaddr[`DSR_IDX_HI:`DSR_IDX_LO];
            end
            if (w_hs) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= `DSR_RESP_OKAY;
                case (aw_idx)
                    `DSR_IDX_CTRL: begin
                        if (w_strb[0]) begin
                            ctrl[7:0] <= w_data[7:0];
                        end
                        if (w_strb[1]) begin
                            ctrl[`DSR_CTRL_W-1:8] <= w_data[`DSR_CTRL_W-1:8];
                        end
                    end
                    `DSR_IDX_SLIP: begin
                        sw_slip <= w_strb[0] & w_data[`DSR_F_SLIP_GO];
                    end
                    `DSR_IDX_STATUS: begin
                        s_axi_bresp <= `DSR_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `DSR_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // AXI4-Lite read side
    // ****************************************
    wire        ar_hs       = s_axi_arvalid & s_axi_arready;
    wire        next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_hs;
    wire [31:0] status_word = {16'h0000, slip_pend, ~cfg_ok, slip_pos, par_word};

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DSR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_hs) begin
                s_axi_rresp <= `DSR_RESP_OKAY;
                case (s_axi_araddr[`DSR_IDX_HI:`DSR_IDX_LO])
                    `DSR_IDX_CTRL: begin
                        s_axi_rdata <= {20'h00000, ctrl};
                    end
                    `DSR_IDX_SLIP: begin
                        s_axi_rdata <= 32'h0000_0000;
                    end
                    `DSR_IDX_STATUS: begin
                        s_axi_rdata <= status_word;
                    end
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `DSR_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

endmodule

// File: hdl/dsr_unit.v
// One six-bit capture chain of the deserializer, cascadable through two carry bits
`include "dsr_consts.vh"

module dsr_unit (
    // Clock and reset
    input  wire                     aclk,
    input  wire                     rst,
    // Mode and enable
    input  wire                     ddr,
    input  wire                     ce_low,
    // Serial or carry input, bit a is the earlier one
    input  wire                     d_a,
    input  wire                     d_b,
    // Captured bits and carry out
    output reg  [`DSR_UNIT_W-1:0]   bits,
    output wire                     carry_a,
    output wire                     carry_b
);

    wire [`DSR_UNIT_W-1:0] next_bits;

    // Newest bits enter at the bottom, so the oldest end up highest
    assign next_bits = ddr ? {bits[`DSR_UNIT_W-3:0], d_a, d_b}
                           : {bits[`DSR_UNIT_W-2:0], d_a};
    assign carry_a   = ddr ? bits[`DSR_UNIT_W-1] : bits[`DSR_UNIT_W-1];
    assign carry_b   = bits[`DSR_UNIT_W-2];

    // ****************************************
    // Capture registers
    // ****************************************
    always @(posedge aclk) begin
        if (rst) begin
            bits <= {`DSR_UNIT_W{1'b0}};
        end else begin
            // Only the low four stages honour the enable; upper stages always shift
            if (ce_low) begin
                bits[`DSR_LOW_GATED-1:0] <= next_bits[`DSR_LOW_GATED-1:0]; // RULE9
            end
            bits[`DSR_UNIT_W-1:`DSR_LOW_GATED] <= next_bits[`DSR_UNIT_W-1:`DSR_LOW_GATED];
        end
    end

endmodule
